// ---- verilog/hbsp_device.sv ----
// device end of the host bus slave port
`timescale 1ns/100ps
// What the document asks of this port, its host and its board
// (RULE1) lowest address line is address bit zero
// (RULE2) low byte enable selects lane 7..0
// (RULE3) upper strobe frames 16-bit direction-line access
// (RULE4) style pin static high selects direction-line
// (RULE5) style pin static low selects strobe-pair
// (RULE6) style pin falling edge selects multiplexed mode
// (RULE7) latch address on latch enable falling edge
// (RULE8) board ties address pins to data
// (RULE9) narrow part on wide bus shifts address; here the address pins reach regAddr unshifted
// (RULE10) single data strobe frames 8-bit direction access
// (RULE11) high byte enable selects lane 15..8
// (RULE12) 8-bit strobe-pair ignores high byte enable
// (RULE13) lower strobe frames 16-bit direction-line access
// (RULE14) drive read data while read strobe low
// (RULE15) host holds direction valid during strobe
// (RULE16) respond only while chip select low
// (RULE17) host holds write data during write strobe
// (RULE18) acknowledge held until strobe or select release
// (RULE19) width pin chooses 8-bit or 16-bit bus
// (RULE20) data lines released except during read
module hbsp_device (
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	hbsp_if.device                    bus,
	output wire hbsp_pkg::hbsp_addr_t regAddr,
	output wire logic [1:0]           regByteEn,
	output wire hbsp_pkg::hbsp_data_t regWrData,
	output wire logic                 regWrite,
	output wire logic                 regRead,
	input  wire hbsp_pkg::hbsp_data_t regRdData,
	input  wire logic                 regDone,
	output wire logic                 wideMode,
	output wire logic                 muxMode
);
	typedef struct packed {
		hbsp_pkg::hbsp_pins_s      sync1;
		hbsp_pkg::hbsp_pins_s      sync2;
		logic                      stylePrev;
		logic                      muxMode;
		logic                      wideMode;
		hbsp_pkg::hbsp_addr_t      muxAddr;
		hbsp_pkg::hbsp_dev_state_e fsm;
		logic                      accRead;
		hbsp_pkg::hbsp_addr_t      regAddr;
		logic [1:0]                regByteEn;
		hbsp_pkg::hbsp_data_t      regWrData;
		logic                      regWrite;
		logic                      regRead;
		hbsp_pkg::hbsp_data_t      devData;
		logic [1:0]                devOe;
		logic                      ackOut;
		logic                      ackOe;
	} hbsp_dev_s;

	localparam hbsp_dev_s DEV_RST = '{sync1: hbsp_pkg::PINS_IDLE,
		sync2: hbsp_pkg::PINS_IDLE, fsm: hbsp_pkg::DEV_IDLE, default: '0};

	hbsp_dev_s s;
	hbsp_dev_s next_s;

	// decode of the synchronised pins, then the access sequencer
	always_comb
	begin
		hbsp_pkg::hbsp_pins_s p;
		hbsp_pkg::hbsp_addr_t base;
		logic                 dirMode;
		logic                 active;
		logic                 isRead;
		logic                 lowBit;
		logic [1:0]           be;
		p       = s.sync2;
		base    = '0;
		dirMode = 1'h0;
		active  = 1'h0;
		isRead  = 1'h0;
		lowBit  = 1'h0;
		be      = hbsp_pkg::BE_LOW;
		next_s  = s;

		// every pin passes two flops before anything looks at it
		next_s.sync1     = bus.seenPins;
		next_s.sync2     = s.sync1;
		next_s.stylePrev = p.styleSel;
		next_s.wideMode  = p.widthSel; // RULE19
		next_s.regWrite  = 1'h0;
		next_s.regRead   = 1'h0;

		// the first falling edge is sticky: the pin is address latch enable from then on
		if (s.stylePrev && !p.styleSel)
		begin
			next_s.muxMode = 1'h1; // RULE6
			next_s.muxAddr = {p.addrHi, p.lowPin}; // RULE7
		end

		// static high without a seen edge is the direction-line style
		dirMode = !s.muxMode && p.styleSel; // RULE4 RULE5

		if (dirMode)
		begin
			isRead = p.rwN; // RULE15
			if (s.wideMode)
			begin
				active = !p.csN && (!p.lowPin || !p.highPin); // RULE3 RULE13 RULE16
				be     = {!p.lowPin, !p.highPin}; // RULE3 RULE13
			end
			else
			begin
				active = !p.csN && !p.highPin; // RULE10 RULE16
				lowBit = p.lowPin; // RULE1
			end
		end
		else
		begin
			active = !p.csN && (!p.rdN || !p.wrN); // RULE16
			isRead = !p.rdN;
			if (s.wideMode)
			begin
				be = {!p.highPin, !p.lowPin}; // RULE2 RULE11
			end
			else
			begin
				lowBit = p.lowPin; // RULE1 RULE12
			end
		end

		// in multiplexed mode the latched address stands in for the address pins
		base = s.muxMode ? s.muxAddr : {p.addrHi, lowBit};
		if (s.wideMode)
		begin
			// word or low byte sits at the even address, a lone high byte at the odd one
			base[0] = (be == hbsp_pkg::BE_HIGH);
		end

		case (s.fsm)
			hbsp_pkg::DEV_IDLE:
			begin
				if (active)
				begin
					next_s.regAddr   = base;
					next_s.regByteEn = be;
					next_s.regWrData = p.data; // RULE17
					next_s.regRead   = isRead;
					next_s.regWrite  = !isRead;
					next_s.accRead   = isRead;
					next_s.ackOe     = 1'h1; // RULE18
					next_s.fsm       = hbsp_pkg::DEV_REQ;
				end
			end
			hbsp_pkg::DEV_REQ:
			begin
				// wait for the register side; a host that gave up gets no answer
				if (regDone)
				begin
					if (active)
					begin
						next_s.ackOut  = 1'h1; // RULE18
						next_s.devData = regRdData;
						next_s.devOe   = s.accRead ? s.regByteEn : 2'h0; // RULE14 RULE20
						next_s.fsm     = hbsp_pkg::DEV_HOLD;
					end
					else
					begin
						next_s.ackOe = 1'h0;
						next_s.fsm   = hbsp_pkg::DEV_IDLE;
					end
				end
			end
			hbsp_pkg::DEV_HOLD:
			begin
				// acknowledge and read data stay up until strobe or select drops
				if (!active)
				begin
					next_s.ackOut = 1'h0; // RULE18
					next_s.ackOe  = 1'h0; // RULE18
					next_s.devOe  = 2'h0; // RULE20
					next_s.fsm    = hbsp_pkg::DEV_IDLE;
				end
			end
			default:
			begin
				next_s = DEV_RST;
			end
		endcase
	end

	// single state register; reset releases every line
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			s <= DEV_RST;
		end
		else
		begin
			s <= next_s;
		end
	end

	// every output is a flop of the state
	assign bus.devData = s.devData;
	assign bus.devOe   = s.devOe;
	assign bus.ackOut  = s.ackOut;
	assign bus.ackOe   = s.ackOe;
	assign regAddr     = s.regAddr;
	assign regByteEn   = s.regByteEn;
	assign regWrData   = s.regWrData;
	assign regWrite    = s.regWrite;
	assign regRead     = s.regRead;
	assign wideMode    = s.wideMode;
	assign muxMode     = s.muxMode;
endmodule : hbsp_device

// ---- verilog/hbsp_pkg.sv ----
// shared types and constants for the host bus slave port
package hbsp_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;

	typedef logic [DATA_W-1:0] hbsp_data_t;
	typedef logic [ADDR_W-1:0] hbsp_addr_t;

	// byte enable codes, bit 0 is the low lane
	localparam logic [1:0] BE_LOW  = 2'h1;
	localparam logic [1:0] BE_HIGH = 2'h2;

	// every pin the host drives towards the device
	typedef struct packed {
		logic                   csN;
		logic                   rdN;
		logic                   wrN;
		logic                   rwN;      // high = read, low = write
		logic                   lowPin;   // lowest_address_line / low_byte_enable / upper_byte_strobe
		logic                   highPin;  // single_data_strobe / high_byte_enable / lower_byte_strobe
		logic                   styleSel; // bus_style_select, doubles as address latch enable
		logic                   widthSel; // high = 16-bit bus
		logic [ADDR_W-1:1]      addrHi;
		hbsp_data_t             data;
	} hbsp_pins_s;

	// idle pin levels; style and width start low so no false latch edge follows reset
	localparam hbsp_pins_s PINS_IDLE = '{csN: 1'h1, rdN: 1'h1, wrN: 1'h1, rwN: 1'h1,
		lowPin: 1'h1, highPin: 1'h1, styleSel: 1'h0, widthSel: 1'h0, addrHi: '0, data: '0};

	typedef enum logic [1:0] {
		HBSP_STROBE_PAIR = 2'h0,
		HBSP_DIRECTION   = 2'h1,
		HBSP_MUXED       = 2'h2
	} hbsp_style_e;

	typedef enum logic [2:0] {
		DEV_IDLE = 3'h1,
		DEV_REQ  = 3'h2,
		DEV_HOLD = 3'h4
	} hbsp_dev_state_e;

	typedef enum logic [5:0] {
		HST_IDLE    = 6'h01,
		HST_ALE_HI  = 6'h02,
		HST_ALE_LO  = 6'h04,
		HST_SETUP   = 6'h08,
		HST_STROBE  = 6'h10,
		HST_RELEASE = 6'h20
	} hbsp_host_state_e;

	// host holds each pin phase long enough for the device's two-stage synchroniser
	localparam int CLK_PERIOD_NS = 4;
	localparam int HOST_PHASE_NS = 16;
	localparam logic [3:0] HOST_PHASE_CYC =
		4'((HOST_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : hbsp_pkg

// ---- verilog/hbsp_if.sv ----
// pin-level carrier joining the host end and the device end
`timescale 1ns/100ps
interface hbsp_if;
	hbsp_pkg::hbsp_pins_s hostPins;
	logic                 hostOe;
	hbsp_pkg::hbsp_data_t devData;
	logic [1:0]           devOe;
	logic                 ackOut;
	logic                 ackOe;
	hbsp_pkg::hbsp_pins_s seenPins;
	hbsp_pkg::hbsp_data_t dataBus;
	hbsp_pkg::hbsp_data_t laneDev;
	logic                 ackLine;

	// wire resolution: device lanes win, undriven data lines float high on pull-ups, an undriven ack line reads low
	assign laneDev = {{hbsp_pkg::BYTE_W{devOe[1]}}, {hbsp_pkg::BYTE_W{devOe[0]}}};
	assign dataBus = (laneDev & devData) | (~laneDev & (hostOe ? hostPins.data : '1));
	assign ackLine = ackOe & ackOut;

	always_comb
	begin
		seenPins      = hostPins;
		seenPins.data = dataBus;
	end

	modport device (input seenPins, output devData, devOe, ackOut, ackOe);
	modport host (input ackLine, dataBus, output hostPins, hostOe);
endinterface : hbsp_if

// ---- verilog/hbsp_host.sv ----
// host end of the host bus slave port: drives one access per command
`timescale 1ns/100ps
module hbsp_host (
	input  wire logic                  clk_sys,
	input  wire logic                  rstn,
	hbsp_if.host                       bus,
	input  wire hbsp_pkg::hbsp_style_e style,
	input  wire logic                  wide,
	input  wire logic                  cmdValid,
	input  wire logic                  cmdWrite,
	input  wire hbsp_pkg::hbsp_addr_t  cmdAddr,
	input  wire logic [1:0]            cmdByteEn,
	input  wire hbsp_pkg::hbsp_data_t  cmdWrData,
	output wire logic                  cmdReady,
	output wire logic                  rspValid,
	output wire hbsp_pkg::hbsp_data_t  rspRdData
);
	typedef struct packed {
		logic                 ack;
		hbsp_pkg::hbsp_data_t data;
	} hbsp_rsp_s;

	typedef struct packed {
		hbsp_rsp_s                  sync1;
		hbsp_rsp_s                  sync2;
		hbsp_pkg::hbsp_host_state_e fsm;
		logic [3:0]                 cnt;
		logic                       write;
		logic [1:0]                 be;
		hbsp_pkg::hbsp_data_t       wrData;
		hbsp_pkg::hbsp_pins_s       pins;
		logic                       hostOe;
		logic                       cmdReady;
		logic                       rspValid;
		hbsp_pkg::hbsp_data_t       rspRdData;
	} hbsp_hst_s;

	localparam hbsp_hst_s HST_RST = '{pins: hbsp_pkg::PINS_IDLE,
		fsm: hbsp_pkg::HST_IDLE, default: '0};

	hbsp_hst_s s;
	hbsp_hst_s next_s;

	always_comb
	begin
		logic phaseDone;
		logic isDir;
		phaseDone = (s.cnt == hbsp_pkg::HOST_PHASE_CYC - 4'h1);
		isDir     = (style == hbsp_pkg::HBSP_DIRECTION);
		next_s    = s;

		// ack and read data come from the other party: two flops first
		next_s.sync1    = '{ack: bus.ackLine, data: bus.dataBus};
		next_s.sync2    = s.sync1;
		next_s.cnt      = s.cnt + 4'h1;
		next_s.rspValid = 1'h0;
		next_s.pins.widthSel = wide;

		case (s.fsm)
			hbsp_pkg::HST_IDLE:
			begin
				// style pin is static except in multiplexed mode, where it idles low
				next_s.pins.styleSel = isDir; // RULE4 RULE5
				next_s.cmdReady      = 1'h1;
				if (cmdValid && s.cmdReady)
				begin
					next_s.cmdReady    = 1'h0;
					next_s.write       = cmdWrite;
					next_s.be          = wide ? cmdByteEn : hbsp_pkg::BE_LOW;
					next_s.wrData      = cmdWrData;
					next_s.pins.addrHi = cmdAddr[hbsp_pkg::ADDR_W-1:1];
					next_s.pins.rwN    = !cmdWrite; // RULE15
					// narrow modes carry bit zero; wide strobe-pair carries byte enables
					next_s.pins.lowPin  = (wide && !isDir) ? !cmdByteEn[0] : cmdAddr[0];
					// narrow strobe-pair still swings the unused high enable, so a device
					// that wrongly decodes it shows up as a lane or address error
					next_s.pins.highPin = !(!isDir && cmdByteEn[1]); // RULE11 RULE12
					if (isDir && wide)
					begin
						next_s.pins.lowPin = 1'h1;
					end
					// address also rides on the data lines for the multiplexed bus
					next_s.pins.data = cmdAddr; // RULE8
					next_s.hostOe    = (style == hbsp_pkg::HBSP_MUXED);
					next_s.cnt       = 4'h0;
					next_s.fsm       = (style == hbsp_pkg::HBSP_MUXED) ?
						hbsp_pkg::HST_ALE_HI : hbsp_pkg::HST_SETUP;
				end
			end
			hbsp_pkg::HST_ALE_HI:
			begin
				next_s.pins.styleSel = 1'h1;
				if (phaseDone)
				begin
					next_s.pins.styleSel = 1'h0;
					next_s.cnt           = 4'h0;
					next_s.fsm           = hbsp_pkg::HST_ALE_LO;
				end
			end
			hbsp_pkg::HST_ALE_LO:
			begin
				if (phaseDone)
				begin
					next_s.cnt = 4'h0;
					next_s.fsm = hbsp_pkg::HST_SETUP;
				end
			end
			hbsp_pkg::HST_SETUP:
			begin
				// write data settles three cycles before the strobe
				next_s.pins.data = s.wrData; // RULE17
				next_s.hostOe    = s.write;
				// address pins are tied to the data lines on the multiplexed bus, so after
				// the latch they follow data and only the latched address is meaningful
				if (style == hbsp_pkg::HBSP_MUXED)
				begin
					next_s.pins.addrHi = s.write ? s.wrData[hbsp_pkg::ADDR_W-1:1] : '1; // RULE8
					if (!wide)
					begin
						next_s.pins.lowPin = s.write ? s.wrData[0] : 1'h1; // RULE8
					end
				end
				if (phaseDone)
				begin
					next_s.pins.csN = 1'h0;
					if (isDir)
					begin
						next_s.pins.highPin = wide ? !s.be[0] : 1'h0;
						next_s.pins.lowPin  = wide ? !s.be[1] : s.pins.lowPin;
					end
					else
					begin
						next_s.pins.rdN = s.write;
						next_s.pins.wrN = !s.write;
					end
					next_s.fsm = hbsp_pkg::HST_STROBE;
				end
			end
			hbsp_pkg::HST_STROBE:
			begin
				// no timeout: a device that never answers stalls the host
				if (s.sync2.ack)
				begin
					next_s.rspValid     = 1'h1;
					next_s.rspRdData    = s.sync2.data;
					next_s.pins.csN     = 1'h1;
					next_s.pins.rdN     = 1'h1;
					next_s.pins.wrN     = 1'h1;
					next_s.pins.highPin = 1'h1;
					next_s.pins.lowPin  = 1'h1;
					next_s.hostOe       = 1'h0;
					next_s.fsm          = hbsp_pkg::HST_RELEASE;
				end
			end
			hbsp_pkg::HST_RELEASE:
			begin
				if (!s.sync2.ack)
				begin
					next_s.fsm = hbsp_pkg::HST_IDLE;
				end
			end
			default:
			begin
				next_s = HST_RST;
			end
		endcase
	end

	// single state register
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			s <= HST_RST;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign bus.hostPins = s.pins;
	assign bus.hostOe   = s.hostOe;
	assign cmdReady     = s.cmdReady;
	assign rspValid     = s.rspValid;
	assign rspRdData    = s.rspRdData;
endmodule : hbsp_host

// ---- dv/hbsp_asserts.sv ----
// checker for the pins between host end and device end
`timescale 1ns/100ps
module hbsp_asserts (
	input wire logic                 clk_sys,
	input wire logic                 rstn,
	input wire hbsp_pkg::hbsp_pins_s hostPins,
	input wire logic                 hostOe,
	input wire hbsp_pkg::hbsp_data_t devData,
	input wire logic [1:0]           devOe,
	input wire logic                 ackOut,
	input wire logic                 ackOe
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	logic [4:0] curPins;
	logic [4:0] lastPins;
	logic [4:0] pinQuiet;
	logic [4:0] selIdle;

	assign curPins = {hostPins.csN, hostPins.rdN, hostPins.wrN, hostPins.lowPin,
		hostPins.highPin};

	// cycles since a framing pin last rose, and since select went away; saturate, never wrap
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			lastPins <= 5'h1F;
			pinQuiet <= 5'h0;
			selIdle  <= 5'h0;
		end
		else
		begin
			lastPins <= curPins;
			pinQuiet <= (|(curPins & ~lastPins)) ? 5'h0 :
				((pinQuiet == 5'h1F) ? pinQuiet : pinQuiet + 5'h1);
			selIdle  <= !hostPins.csN ? 5'h0 : ((selIdle == 5'h1F) ? selIdle : selIdle + 5'h1);
		end
	end

	sequence s_selRelease;
		$rose(hostPins.csN);
	endsequence
	sequence s_allReleased;
		##[1:5] (!ackOe && devOe == 2'h0);
	endsequence
	sequence s_ackStart;
		$rose(ackOe);
	endsequence

	property p_ack_release;  s_selRelease |-> s_allReleased; endproperty
	property p_ack_held;     $fell(ackOe) |-> pinQuiet <= 5'h5; endproperty
	property p_ack_sel;      s_ackStart |-> !hostPins.csN; endproperty
	property p_ack_strobe;
		s_ackStart |-> (!hostPins.rdN || !hostPins.wrN || !hostPins.lowPin || !hostPins.highPin);
	endproperty
	property p_no_fight;     devOe != 2'h0 |-> !hostOe; endproperty
	property p_rd_sel;       devOe != 2'h0 |-> selIdle <= 5'h5; endproperty
	property p_narrow_lane;  (devOe != 2'h0 && !hostPins.widthSel) |-> devOe == 2'h1; endproperty
	property p_rd_stable;    (devOe != 2'h0 && $past(devOe) != 2'h0) |-> $stable(devData); endproperty
	// the line is driven inactive while the register side is busy, so only the reverse holds
	property p_ack_level;    ackOut |-> ackOe; endproperty

	a_ack_release: assert property (p_ack_release) else $error("ack or data kept after release");
	a_ack_held: assert property (p_ack_held) else $error("ack dropped while still framed");
	a_ack_sel: assert property (p_ack_sel) else $error("ack without select");
	a_ack_strobe: assert property (p_ack_strobe) else $error("ack without strobe");
	a_no_fight: assert property (p_no_fight) else $error("both ends drive data");
	a_rd_sel: assert property (p_rd_sel) else $error("data driven while unselected");
	a_narrow_lane: assert property (p_narrow_lane) else $error("upper lane in narrow mode");
	a_rd_stable: assert property (p_rd_stable) else $error("read data moved");
	a_ack_level: assert property (p_ack_level) else $error("ack active but not driven");
endmodule : hbsp_asserts

// ---- dv/hbsp_tb_top.sv ----
// testbench: host end and device end joined, random register traffic in every style
`timescale 1ns/100ps
module hbsp_tb_top;
	logic                  clk_sys, rstn, wide, cmdValid, cmdWrite, cmdReady, rspValid;
	logic                  regWrite, regRead, regDone, wideMode, muxMode, seenWr;
	hbsp_pkg::hbsp_style_e style;
	hbsp_pkg::hbsp_addr_t  cmdAddr, regAddr, seenAddr;
	logic [1:0]            cmdByteEn, regByteEn, seenBe;
	hbsp_pkg::hbsp_data_t  cmdWrData, rspRdData, regWrData, regRdData, seenWd;
	int                    failCount, compares, pulseCnt;
	logic [31:0]           seed, r2;

	hbsp_if i_hbsp_if ();
	hbsp_host i_hbsp_host (.clk_sys(clk_sys), .rstn(rstn), .bus(i_hbsp_if), .style(style),
		.wide(wide), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
		.cmdByteEn(cmdByteEn), .cmdWrData(cmdWrData), .cmdReady(cmdReady),
		.rspValid(rspValid), .rspRdData(rspRdData));
	hbsp_device i_hbsp_device (.clk_sys(clk_sys), .rstn(rstn), .bus(i_hbsp_if),
		.regAddr(regAddr), .regByteEn(regByteEn), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData), .regDone(regDone), .wideMode(wideMode),
		.muxMode(muxMode));
	hbsp_asserts i_hbsp_asserts (.clk_sys(clk_sys), .rstn(rstn),
		.hostPins(i_hbsp_if.hostPins), .hostOe(i_hbsp_if.hostOe), .devData(i_hbsp_if.devData),
		.devOe(i_hbsp_if.devOe), .ackOut(i_hbsp_if.ackOut), .ackOe(i_hbsp_if.ackOe));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	// register contents are a fixed function of the address, so reads need no memory
	function automatic hbsp_pkg::hbsp_data_t rdVal(input hbsp_pkg::hbsp_addr_t a);
		return a ^ 16'hC35A;
	endfunction : rdVal

	task automatic check(input hbsp_pkg::hbsp_data_t seen, exp, input string what);
		compares++;
		if (seen !== exp)
		begin
			failCount++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task give_verdict;
		$display("compares %0d mismatches %0d", compares, failCount);
		if (failCount == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict

	initial
	begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end

	// register side: answers one cycle after each request and records what it saw;
	// cleared by reset here so that this block stays the only driver of its signals
	always @(posedge clk_sys)
	begin
		regRdData <= rdVal(regAddr);
		if (!rstn)
		begin
			regDone  <= 1'h0;
			pulseCnt <= 0;
		end
		else
		begin
			regDone <= regRead | regWrite;
			if (regRead | regWrite)
			begin
				seenAddr <= regAddr;
				seenBe   <= regByteEn;
				seenWd   <= regWrData;
				seenWr   <= regWrite;
				pulseCnt <= pulseCnt + 1;
			end
		end
	end

	// one command through the host end, then every register-side effect compared
	task automatic access(input logic w, input hbsp_pkg::hbsp_addr_t a, input logic [1:0] be,
		input hbsp_pkg::hbsp_data_t d);
		logic [1:0]           eb;
		hbsp_pkg::hbsp_addr_t ea;
		hbsp_pkg::hbsp_data_t m;
		int                   n;
		int                   k;
		eb = wide ? be : 2'h1;
		ea = wide ? {a[15:1], eb == 2'h2} : a;
		m = {{8{eb[1]}}, {8{eb[0]}}};
		n = pulseCnt;
		k = 0;
		while (cmdReady !== 1'h1 && k < 100)
		begin
			@(negedge clk_sys);
			k++;
		end
		@(posedge clk_sys);
		cmdValid  <= 1'h1;
		cmdWrite  <= w;
		cmdAddr   <= a;
		cmdByteEn <= be;
		cmdWrData <= d;
		@(posedge clk_sys);
		cmdValid <= 1'h0;
		k = 0;
		do
		begin
			@(negedge clk_sys);
			k++;
		end
		while (rspValid !== 1'h1 && k < 300);
		check(16'(k < 300), 16'h1, "no answer");
		check(16'(pulseCnt - n), 16'h1, "request count");
		check(seenAddr, ea, "address");
		check(16'(seenBe), 16'(eb), "lanes");
		check(16'(seenWr), 16'(w), "direction");
		if (w)
			check(seenWd & m, d & m, "write data");
		else
			check(rspRdData & m, rdVal(ea) & m, "read data");
	endtask : access

	initial
	begin
		rstn = 1'h0;
		wide = 1'h0;
		style = hbsp_pkg::HBSP_STROBE_PAIR;
		cmdValid = 1'h0;
		cmdWrite = 1'h0;
		cmdAddr = 16'h0;
		cmdByteEn = 2'h3;
		cmdWrData = 16'h0;
		seed = 32'h4DFA;
		// each style and width needs its own reset, since mux mode sticks
		for (int c = 0; c < 6; c++)
		begin
			@(posedge clk_sys);
			rstn  <= 1'h0;
			style <= hbsp_pkg::hbsp_style_e'(c / 2);
			wide  <= 1'(c % 2);
			repeat (10) @(posedge clk_sys);
			rstn <= 1'h1;
			access(1'h1, 16'hFFFF, 2'h2, 16'hA55A);
			access(1'h0, 16'hFFFF, 2'h2, 16'h0);
			access(1'h0, 16'h0000, 2'h1, 16'h0);
			access(1'h1, 16'h0001, 2'h3, 16'h1234);
			for (int i = 0; i < 10; i++)
			begin
				seed = xs(seed);
				r2 = xs(seed);
				seed = r2;
				access(r2[0], seed[31:16], (r2[2:1] == 2'h0) ? 2'h3 : r2[2:1], r2[23:8]);
			end
			check(16'(wideMode), 16'(wide), "width mode");
			check(16'(muxMode), 16'(c >= 4), "mux mode");
			$display("test style %0d wide %0d done", c / 2, c % 2);
		end
		give_verdict();
	end

	// six settings, each a reset plus fourteen accesses at their worst-case wait
	localparam int WATCHDOG_CYC = 6 * (12 + 14 * 400);

	initial
	begin
		repeat (WATCHDOG_CYC) @(posedge clk_sys);
		failCount++;
		$display("[FAIL] %0t watchdog expired", $time);
		give_verdict();
	end
endmodule : hbsp_tb_top
